//--- hw/nric_map.svh
/*
 Constants for the NAND reset and identification controller: APB register
 offsets, field positions, reset values, command codes and timing counts.
 Assumes inclusion by its bare name from the controller's design files.
*/
`ifndef NRIC_MAP_SVH
`define NRIC_MAP_SVH

// APB register offsets (byte addresses)
`define NRIC_CTRL_OFS      12'h000
`define NRIC_STAT_OFS      12'h004
`define NRIC_DATA_OFS      12'h008
`define NRIC_COL_OFS       12'h00C
`define NRIC_ID0_OFS       12'h010
`define NRIC_ID1_OFS       12'h014
// Control fields
`define NRIC_CTRL_GO_BIT   0
`define NRIC_CTRL_OP_LSB   1
`define NRIC_CTRL_CNT_LSB  8
// Status fields
`define NRIC_STAT_BUSY_BIT 0
`define NRIC_STAT_DONE_BIT 1
`define NRIC_STAT_INIT_BIT 2
`define NRIC_STAT_ERR_BIT  3
`define NRIC_STAT_RB_BIT   4
// Command codes and address cycles
`define NRIC_CMD_RESET     8'hFF
`define NRIC_CMD_ID        8'h90
`define NRIC_CMD_PARAM     8'hEC
`define NRIC_CMD_STATUS    8'h70
`define NRIC_CMD_READ      8'h00
`define NRIC_CMD_RND1      8'h05
`define NRIC_CMD_RND2      8'hE0
`define NRIC_ADDR_ID       8'h00
`define NRIC_ADDR_ONFI     8'h20
// Expected identifier fixed fields
`define NRIC_ID2_VAL       8'h90
`define NRIC_ID4_VAL       8'h04
// Status after reset, by write-protect level
`define NRIC_SR_WP_HI      8'hE0
`define NRIC_SR_WP_LO      8'h60
// Timing
`define NRIC_CLK_MHZ       50
`define NRIC_RST_MAX_US    1000
`define NRIC_RST_MAX_CYC   (`NRIC_RST_MAX_US * `NRIC_CLK_MHZ)
`define NRIC_STROBE_CYC    4
`define NRIC_PP_LEN        256

`endif

//--- hw/nric_pkg.sv
/*
 Types for the NAND reset and identification controller.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package nric_pkg;
   typedef enum logic [1:0] {
      NRIC_OP_RESET = 2'b00,
      NRIC_OP_ID    = 2'b01,
      NRIC_OP_ONFI  = 2'b10,
      NRIC_OP_PARAM = 2'b11
   } nric_op_t;
   typedef enum logic [1:0] {
      NRIC_CYC_CMD  = 2'b00,
      NRIC_CYC_ADDR = 2'b01,
      NRIC_CYC_READ = 2'b10
   } nric_cyc_t;
endpackage

//--- hw/nric_cyc_if.sv
/*
 Bus-cycle request carrier between the controller sequencer and the
 pin driver. Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
interface nric_cyc_if;
   import nric_pkg::*;
   logic       req;
   nric_cyc_t  kind;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   modport seq (output req, output kind, output wdata, input ack, input rdata);
   modport drv (input req, input kind, input wdata, output ack, output rdata);
endinterface

//--- hw/nric_pin_drv.sv
/*
 Pin driver: turns one command, address or read cycle into strobe pulses.
 Assumes the NAND pins have settled timing at 20 ns per clock; read data
 is sampled at the end of the read-enable low phase.
*/
`timescale 1ns/1ps
`include "nric_map.svh"
module nric_pin_drv
   import nric_pkg::*;
#(
   parameter int STROBE_CYC = `NRIC_STROBE_CYC
)(
   input  wire logic  pclk,
   input  wire logic  presetn,
   nric_cyc_if.drv    cyc,
   output logic       nand_cle,
   output logic       nand_ale,
   output logic       nand_we_n,
   output logic       nand_re_n,
   output logic [7:0] nand_io_o,
   output logic       nand_io_oe_n,
   input  wire logic [7:0] nand_io_i
);
   logic [3:0] cnt_reg;
   logic       act_reg;
   logic [7:0] rd_reg;

   // Phase counter: low half then high half of the strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
         act_reg <= 1'b0;
      end else if (!act_reg && cyc.req) begin
         act_reg <= 1'b1;
         cnt_reg <= 4'h0;
      end else if (act_reg) begin
         if (cnt_reg == 4'(2 * STROBE_CYC - 1)) begin
            act_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Pin levels, all from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nand_cle     <= 1'b0;
         nand_ale     <= 1'b0;
         nand_we_n    <= 1'b1;
         nand_re_n    <= 1'b1;
         nand_io_o    <= 8'h00;
         nand_io_oe_n <= 1'b1;
         rd_reg       <= 8'h00;
      end else if (!act_reg && cyc.req) begin
         nand_cle     <= (cyc.kind == NRIC_CYC_CMD);
         nand_ale     <= (cyc.kind == NRIC_CYC_ADDR);
         nand_we_n    <= (cyc.kind == NRIC_CYC_READ);
         nand_re_n    <= (cyc.kind != NRIC_CYC_READ);
         nand_io_o    <= cyc.wdata;
         nand_io_oe_n <= (cyc.kind == NRIC_CYC_READ);
      end else if (act_reg && cnt_reg == 4'(STROBE_CYC - 1)) begin
         if (!nand_re_n) begin
            rd_reg <= nand_io_i;
         end
         nand_we_n <= 1'b1;
         nand_re_n <= 1'b1;
      end else if (!act_reg) begin
         nand_cle     <= 1'b0;
         nand_ale     <= 1'b0;
         nand_io_oe_n <= 1'b1;
      end
   end

   assign cyc.ack   = act_reg && (cnt_reg == 4'(2 * STROBE_CYC - 1));
   assign cyc.rdata = rd_reg;
endmodule

//--- hw/nric_ctrl.sv
/*
 NAND reset and identification controller, host side.
 Software orders reset, identifier reads and parameter page reads over APB;
 the controller issues command, address and read cycles on the NAND pins.
 Assumes one NAND target on the pins and the ready/busy line pulled up.
*/
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "nric_map.svh"
module nric_ctrl
   import nric_pkg::*;
#(
   parameter int RST_MAX_CYC = `NRIC_RST_MAX_CYC,
   parameter int PP_LEN      = `NRIC_PP_LEN
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             nand_ce_n,
   output logic             nand_cle,
   output logic             nand_ale,
   output logic             nand_we_n,
   output logic             nand_re_n,
   output logic             nand_wp_n,
   output logic [7:0]       nand_io_o,
   output logic             nand_io_oe_n,
   input  wire logic [7:0]  nand_io_i,
   input  wire logic        nand_rb_n
);
   typedef enum logic [3:0] {
      NRIC_IDLE  = 4'b0000,
      NRIC_CMD   = 4'b0001,
      NRIC_ADDR  = 4'b0010,
      NRIC_WBUSY = 4'b0011,
      NRIC_READ  = 4'b0100,
      NRIC_RCMD1 = 4'b0101,
      NRIC_RADDR = 4'b0110,
      NRIC_RCMD2 = 4'b0111,
      NRIC_WAIT  = 4'b1000
   } nric_state_t;

   nric_cyc_if cyc ();

   nric_state_t state_reg;
   nric_op_t    op_reg;
   logic [8:0]  left_reg;
   logic [7:0]  byte_reg;
   logic        byte_vld_reg;
   logic        busy_reg;
   logic        done_reg;
   logic        init_reg;
   logic        err_reg;
   logic [39:0] id_reg;
   logic [2:0]  id_idx_reg;
   logic [7:0]  col_reg;
   logic        col_pend_reg;
   logic [31:0] tmo_reg;
   logic [2:0]  rb_sync_reg;
   logic        rb_reg;
   logic        wr_go;
   logic        rd_data;
   logic        apb_acc;

   assign apb_acc = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_go   = apb_acc && pwrite && (paddr == `NRIC_CTRL_OFS)
                    && pwdata[`NRIC_CTRL_GO_BIT] && !busy_reg;
   assign rd_data = apb_acc && !pwrite && (paddr == `NRIC_DATA_OFS);
   assign nand_ce_n = 1'b0;
   assign nand_wp_n = 1'b1;

   // Ready/busy pin synchroniser; a level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_sync_reg <= 3'b111;
         rb_reg      <= 1'b1;
      end else begin
         rb_sync_reg <= {rb_sync_reg[1:0], nand_rb_n};
         if (rb_sync_reg[1] == rb_sync_reg[2]) begin
            rb_reg <= rb_sync_reg[2];
         end
      end
   end

   // APB read mux
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `NRIC_STAT_OFS: prdata = {27'h0, rb_reg, err_reg, init_reg, done_reg, busy_reg};
         `NRIC_DATA_OFS: prdata = {23'h0, byte_vld_reg, byte_reg};
         `NRIC_COL_OFS:  prdata = {24'h0, col_reg};
         `NRIC_ID0_OFS:  prdata = id_reg[31:0];
         `NRIC_ID1_OFS:  prdata = {24'h0, id_reg[39:32]};
         default:        prdata = 32'h0000_0000;
      endcase
   end

   // Column register for random data read; write arms a reposition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_reg      <= 8'h00;
         col_pend_reg <= 1'b0;
      end else if (apb_acc && pwrite && paddr == `NRIC_COL_OFS) begin
         col_reg      <= pwdata[7:0];
         col_pend_reg <= 1'b1;
      end else if (state_reg == NRIC_RCMD1) begin
         col_pend_reg <= 1'b0;
      end
   end

   // Main sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= NRIC_IDLE;
         op_reg     <= NRIC_OP_RESET;
         left_reg   <= 9'h000;
         busy_reg   <= 1'b0;
         done_reg   <= 1'b0;
         init_reg   <= 1'b0;
         err_reg    <= 1'b0;
         tmo_reg    <= 32'h0000_0000;
         id_idx_reg <= 3'h0;
      end else begin
         case (state_reg)
            NRIC_IDLE: begin
               if (wr_go) begin
                  op_reg   <= nric_op_t'(pwdata[`NRIC_CTRL_OP_LSB +: 2]);
                  left_reg <= pwdata[`NRIC_CTRL_CNT_LSB +: 9];
                  busy_reg <= 1'b1;
                  done_reg <= 1'b0;
                  err_reg  <= 1'b0;
                  // Nothing but reset before the first reset or while the target is busy
                  if ((!init_reg || !rb_reg) &&
                      pwdata[`NRIC_CTRL_OP_LSB +: 2] != 2'(NRIC_OP_RESET)) begin
                     busy_reg <= 1'b0;
                     err_reg  <= 1'b1;
                  end else begin
                     state_reg <= NRIC_CMD;
                  end
               end
            end
            NRIC_CMD: begin
               if (cyc.ack) begin
                  id_idx_reg <= 3'h0;
                  tmo_reg    <= 32'h0000_0000;
                  state_reg  <= (op_reg == NRIC_OP_RESET) ? NRIC_WBUSY : NRIC_ADDR;
               end
            end
            NRIC_ADDR: begin
               if (cyc.ack) begin
                  state_reg <= (op_reg == NRIC_OP_PARAM) ? NRIC_WBUSY : NRIC_READ;
               end
            end
            NRIC_WBUSY: begin
               // Wait more than eight cycles, then for ready/busy high
               tmo_reg <= tmo_reg + 32'h1;
               if (tmo_reg > 32'(RST_MAX_CYC) && op_reg == NRIC_OP_RESET) begin
                  err_reg   <= 1'b1;
                  busy_reg  <= 1'b0;
                  state_reg <= NRIC_IDLE;
               end else if (tmo_reg > 32'h8 && rb_reg) begin
                  if (op_reg == NRIC_OP_RESET) begin
                     init_reg  <= 1'b1;
                     done_reg  <= 1'b1;
                     busy_reg  <= 1'b0;
                     state_reg <= NRIC_IDLE;
                  end else begin
                     state_reg <= NRIC_READ;
                  end
               end
            end
            NRIC_READ: begin
               if (cyc.ack) begin
                  id_idx_reg <= id_idx_reg + 3'h1;
                  left_reg   <= left_reg - 9'h001;
                  state_reg  <= NRIC_WAIT;
               end
            end
            NRIC_WAIT: begin
               if (left_reg == 9'h000) begin
                  done_reg  <= 1'b1;
                  busy_reg  <= 1'b0;
                  state_reg <= NRIC_IDLE;
               end else if (op_reg == NRIC_OP_PARAM && col_pend_reg) begin
                  state_reg <= NRIC_RCMD1;
               end else if (!byte_vld_reg) begin
                  state_reg <= NRIC_READ;
               end
            end
            NRIC_RCMD1: if (cyc.ack) state_reg <= NRIC_RADDR;
            NRIC_RADDR: if (cyc.ack) state_reg <= NRIC_RCMD2;
            NRIC_RCMD2: if (cyc.ack) state_reg <= NRIC_WAIT;
            default: state_reg <= NRIC_IDLE;
         endcase
      end
   end

   // Byte handed to software; reading the data register frees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_reg     <= 8'h00;
         byte_vld_reg <= 1'b0;
      end else if (state_reg == NRIC_READ && cyc.ack) begin
         byte_reg     <= cyc.rdata;
         byte_vld_reg <= 1'b1;
      end else if (rd_data || (state_reg == NRIC_CMD && op_reg == NRIC_OP_RESET)) begin
         byte_vld_reg <= 1'b0;
      end
   end

   // Identifier bytes captured in order; first five kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         id_reg <= 40'h00_0000_0000;
      end else if (state_reg == NRIC_READ && cyc.ack && op_reg != NRIC_OP_PARAM
                   && id_idx_reg < 3'h5) begin
         id_reg[id_idx_reg*8 +: 8] <= cyc.rdata;
      end
   end

   // Cycle requests to the pin driver
   always_comb begin
      cyc.req   = 1'b0;
      cyc.kind  = NRIC_CYC_CMD;
      cyc.wdata = 8'h00;
      case (state_reg)
         NRIC_CMD: begin
            cyc.req = 1'b1;
            case (op_reg)
               NRIC_OP_RESET: cyc.wdata = `NRIC_CMD_RESET;
               NRIC_OP_PARAM: cyc.wdata = `NRIC_CMD_PARAM;
               default:       cyc.wdata = `NRIC_CMD_ID;
            endcase
         end
         NRIC_ADDR: begin
            cyc.req   = 1'b1;
            cyc.kind  = NRIC_CYC_ADDR;
            cyc.wdata = (op_reg == NRIC_OP_ONFI) ? `NRIC_ADDR_ONFI : `NRIC_ADDR_ID;
         end
         NRIC_READ: begin
            cyc.req  = 1'b1;
            cyc.kind = NRIC_CYC_READ;
         end
         NRIC_RCMD1: begin
            cyc.req   = 1'b1;
            cyc.wdata = `NRIC_CMD_RND1;
         end
         NRIC_RADDR: begin
            cyc.req   = 1'b1;
            cyc.kind  = NRIC_CYC_ADDR;
            cyc.wdata = col_reg;
         end
         NRIC_RCMD2: begin
            cyc.req   = 1'b1;
            cyc.wdata = `NRIC_CMD_RND2;
         end
         default: cyc.req = 1'b0;
      endcase
   end

   nric_pin_drv u_drv (
      .pclk         (pclk),
      .presetn      (presetn),
      .cyc          (cyc.drv),
      .nand_cle     (nand_cle),
      .nand_ale     (nand_ale),
      .nand_we_n    (nand_we_n),
      .nand_re_n    (nand_re_n),
      .nand_io_o    (nand_io_o),
      .nand_io_oe_n (nand_io_oe_n),
      .nand_io_i    (nand_io_i)
   );

   // Checks
   property p_no_cmd_before_init;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_IDLE && $past(state_reg) == NRIC_IDLE) ##1
      (state_reg == NRIC_CMD && op_reg != NRIC_OP_RESET) |-> init_reg;
   endproperty
   a_no_cmd_before_init: assert property (p_no_cmd_before_init) else $error("command before reset");

   property p_reset_sets_init;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_WBUSY && op_reg == NRIC_OP_RESET && rb_reg && tmo_reg > 32'h8
       && tmo_reg <= 32'(RST_MAX_CYC)) |=> (init_reg && done_reg && !busy_reg);
   endproperty
   a_reset_sets_init: assert property (p_reset_sets_init) else $error("reset end not seen");

   property p_timeout_err;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_WBUSY && op_reg == NRIC_OP_RESET && tmo_reg > 32'(RST_MAX_CYC))
      |=> (err_reg && state_reg == NRIC_IDLE);
   endproperty
   a_timeout_err: assert property (p_timeout_err) else $error("reset timeout missed");

   property p_id_addr;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_ADDR && op_reg == NRIC_OP_ONFI) |-> cyc.wdata == `NRIC_ADDR_ONFI;
   endproperty
   a_id_addr: assert property (p_id_addr) else $error("wrong signature address");

   property p_param_busy;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_ADDR && cyc.ack && op_reg == NRIC_OP_PARAM) |=> state_reg == NRIC_WBUSY;
   endproperty
   a_param_busy: assert property (p_param_busy) else $error("no busy wait");

   property p_byte_count;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_READ && cyc.ack) |=> left_reg == $past(left_reg) - 9'h001;
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("byte count slip");

   property p_cmd_code;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_CMD && op_reg == NRIC_OP_PARAM) |-> cyc.wdata == `NRIC_CMD_PARAM;
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("wrong parameter code");

   property p_rnd_seq;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == NRIC_RCMD1 && cyc.ack) |=> state_reg == NRIC_RADDR;
   endproperty
   a_rnd_seq: assert property (p_rnd_seq) else $error("random read order");
endmodule

//--- verification/nric_nand_model.sv
/*
 Behavioural NAND target for the reset and identification controller bench.
 Assumes chip enable, latch enables and strobes from the controller, and a
 resolved io bus; ready/busy is driven here as a plain level.
*/
`timescale 1ns/1ps
module nric_nand_model #(
   parameter logic [7:0]  MAKER  = 8'h3A,         // Arbitrary maker code
   parameter logic [7:0]  DEVICE = 8'h5C,         // Arbitrary device code
   parameter logic [31:0] SIG    = 32'h6D5E3B21,  // Arbitrary signature bytes
   parameter int          RST_NS = 400,
   parameter int          ARR_NS = 600
)(
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic       wp_n,
   input  wire logic [7:0] io_in,
   output logic [7:0]      io_out,
   output logic            rb_n
);
   logic [7:0] cmd_reg, col, status_reg;
   logic       seen_rst, rnd;
   int         ptr, viol, ff_count;
   int         rst_ns = RST_NS;  // Reset busy time; the bench may stretch it
   realtime    busy_t;

   // Byte presented for the current mode and position
   function automatic logic [7:0] byte_at(input int p);
      if (cmd_reg == 8'h90 && col == 8'h20)
         return (p < 4) ? SIG[8*p+:8] : 8'(p) ^ 8'hC3;
      if (cmd_reg == 8'h90) begin
         case (p)
            0: return MAKER;
            1: return DEVICE;
            2: return 8'h90;
            3: return 8'h95;
            4: return 8'h04;
            default: return 8'h00;
         endcase
      end
      if (cmd_reg == 8'hEC)
         return 8'(p % 256) ^ 8'hA5;
      return ~io_out;
   endfunction

   // Power-up state and ready/busy from the busy deadline
   initial begin
      cmd_reg = 8'h00; col = 8'h00; status_reg = 8'h00; io_out = 8'h5A;
      seen_rst = 0; rnd = 0; ptr = 0; viol = 0; ff_count = 0; busy_t = 0;
      rb_n = 1'b1;
      forever begin
         #5;
         rb_n = ($realtime >= busy_t);
      end
   end

   // Command and address latching on the rising write strobe
   always @(posedge we_n) if (ce_n === 1'b0) begin
      if (cle === 1'b1) begin
         if (io_in == 8'hFF) begin
            busy_t = $realtime + rst_ns;
            cmd_reg = 8'hFF; ptr = 0; rnd = 0; seen_rst = 1; ff_count++;
            status_reg = wp_n ? 8'hE0 : 8'h60;
         end else if (!seen_rst || !rb_n) viol++;
         else if (io_in == 8'h78 && cmd_reg == 8'hEC) viol++;
         else if (io_in == 8'h05) rnd = 1;
         else if (io_in == 8'hE0 && rnd) begin
            rnd = 0;
            ptr = col;
         end else begin
            cmd_reg = io_in;
            ptr = 0;
         end
      end else if (ale === 1'b1) begin
         col = io_in;
         if (!rnd) ptr = 0;
         if (cmd_reg == 8'hEC && !rnd && io_in == 8'h00)
            busy_t = $realtime + ARR_NS;
      end
   end

   // One byte per read strobe; the released bus shows the inverse
   always @(negedge re_n) if (ce_n === 1'b0) begin
      if (!rb_n) viol++;
      io_out = byte_at(ptr);
   end
   always @(posedge re_n) if (ce_n === 1'b0 && $realtime > 0) begin
      io_out = ~io_out;
      ptr++;
   end
endmodule

//--- verification/testbench.sv
/*
 Self-checking bench for the NAND reset and identification controller.
 Assumes the controller's APB map and the NAND model beside it.
*/
`timescale 1ns/1ps
`include "nric_map.svh"
module testbench;
   import nric_pkg::*;
   localparam logic [7:0]  MAKER = 8'h3A;         // Arbitrary maker code
   localparam logic [7:0]  DEV   = 8'h5C;         // Arbitrary device code
   localparam logic [31:0] SIG   = 32'h6D5E3B21;  // Arbitrary signature
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, id0;
   logic        ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
   logic [7:0]  io_o, m_out, b;
   wire  [7:0]  bus = oe_n ? m_out : io_o;
   int          bad_count, comparisons, cycles;
   int          ops [6] = '{0, 1, 2, 3, 0, 1};
   int          cnts[6] = '{0, 5, 4, 262, 0, 5};

   nric_ctrl #(.RST_MAX_CYC(200)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nand_ce_n(ce_n), .nand_cle(cle),
      .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
      .nand_io_o(io_o), .nand_io_oe_n(oe_n), .nand_io_i(bus), .nand_rb_n(rb_n));
   nric_nand_model m (
      .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
      .io_in(bus), .io_out(m_out), .rb_n(rb_n));

   // Clock and run-time ceiling
   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("wrong value at %0t: timeout", $time);
         finish_test;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; read data lands in rd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 0; penable <= 0;
   endtask

   // Poll one status bit until it reaches a level
   task automatic wait_st(input int k, input logic v);
      int n;
      n = 0;
      do begin
         apb(0, `NRIC_STAT_OFS, 0);
         n++;
      end while (rd[k] !== v && n < 500);
      check(rd[k], v, "status wait");
   endtask

   task automatic get_byte(output logic [7:0] bo);
      int n;
      n = 0;
      do begin
         apb(0, `NRIC_DATA_OFS, 0);
         n++;
      end while (rd[8] !== 1'b1 && n < 400);
      check(rd[8], 1, "data valid");
      bo = rd[7:0];
   endtask

   function automatic logic [7:0] exp_byte(input int op, input int i);
      logic [7:0] id [5];
      int v;
      id = '{MAKER, DEV, 8'h90, 8'h95, 8'h04};
      if (op == 1) return id[i];
      if (op == 2) return SIG[8*i+:8];
      v = (i < 258) ? i % 256 : 7 + i - 258;
      return v[7:0] ^ 8'hA5;
   endfunction

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
      bad_count = 0; comparisons = 0; cycles = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      // Identifier order before any reset is refused
      apb(0, `NRIC_STAT_OFS, 0);
      check(rd[2:0], 0, "idle status");
      apb(1, `NRIC_CTRL_OFS, 32'h0000_0503);
      apb(0, `NRIC_STAT_OFS, 0);
      check(rd[3], 1, "refused op");
      check(m.viol, 0, "early command");
      $display("test early order done");
      // Table of operations: reset, id, signature, param page, reset, id
      for (int t = 0; t < 6; t++) begin
         apb(1, `NRIC_CTRL_OFS, 32'(1 | (ops[t] << 1) | (cnts[t] << 8)));
         if (ops[t] == 0) begin
            apb(1, `NRIC_CTRL_OFS, 32'h1);
            wait_st(4, 0);
            check(rd[0], 1, "busy during reset");
         end
         for (int i = 0; i < cnts[t]; i++) begin
            if (ops[t] == 3 && i == 257) apb(1, `NRIC_COL_OFS, 32'h7);
            get_byte(b);
            check(b, exp_byte(ops[t], i), "byte");
            if (i < 4) id0[8*i+:8] = exp_byte(ops[t], i);
         end
         wait_st(0, 0);
         check(rd[1], 1, "done");
         check(rd[4], 1, "ready pin");
         if (ops[t] == 0) begin
            check(rd[2], 1, "init");
            check(m.ff_count, t == 0 ? 1 : 2, "reset count");
            check(m.status_reg, 8'hE0, "status after reset");
         end
         if (ops[t] == 1) begin
            apb(0, `NRIC_ID0_OFS, 0);
            check(rd, id0, "id0");
            apb(0, `NRIC_ID1_OFS, 0);
            check(rd[7:0], 8'h04, "id1");
         end
         $display("test op %0d done", ops[t]);
      end
      // Device slower than the reset limit: the controller flags an error
      m.rst_ns = 6000;
      apb(1, `NRIC_CTRL_OFS, 32'h1);
      wait_st(0, 0);
      check(rd[3:1], 3'b110, "reset timeout");
      wait_st(4, 1);
      $display("test reset timeout done");
      check(m.viol, 0, "protocol faults");
      // Unmapped place reads zero and ignores writes
      apb(1, 12'h0F0, 32'hFFFF_FFFF);
      apb(0, 12'h0F0, 0);
      check(rd, 0, "unmapped");
      check({pready, pslverr}, 2'b10, "response");
      $display("test unmapped done");
      finish_test;
   end
endmodule
